// File: rtl/pdrx_pkg.sv
// package: register map, field positions and reset values of the power-down and format bank
package pdrx_pkg;
   localparam int           PDRX_ADDR_W      = 6;
   localparam int           PDRX_DATA_W      = 8;
   localparam int           PDRX_SAMPLE_W    = 12;
   // register offsets
   localparam logic [5:0]   PDRX_OFS_SOFT    = 6'h00;
   localparam logic [5:0]   PDRX_OFS_PWR     = 6'h02;
   localparam logic [5:0]   PDRX_OFS_RXA_PD  = 6'h03;
   localparam logic [5:0]   PDRX_OFS_RXB_PD  = 6'h04;
   localparam logic [5:0]   PDRX_OFS_RX_REF  = 6'h05;
   localparam logic [5:0]   PDRX_OFS_RXA_FMT = 6'h06;
   localparam logic [5:0]   PDRX_OFS_RXB_FMT = 6'h07;
   // field positions
   localparam int           PDRX_BIT_SOFT_RST = 5;
   localparam int           PDRX_TXA_MSB      = 7;
   localparam int           PDRX_TXA_LSB      = 5;
   localparam int           PDRX_BIT_TX_DIG   = 4;
   localparam int           PDRX_BIT_RX_DIG   = 3;
   localparam int           PDRX_BIT_PLL_PD   = 2;
   localparam int           PDRX_BIT_PLL_DIS  = 1;
   localparam int           PDRX_BIT_CH_ANA   = 7;
   localparam int           PDRX_BIT_CH_BIAS  = 6;
   localparam int           PDRX_BIT_ANA_BIAS = 7;
   localparam int           PDRX_BIT_RX_REF   = 6;
   localparam int           PDRX_BIT_DIFF_REF = 5;
   localparam int           PDRX_BIT_VREF     = 4;
   localparam int           PDRX_BIT_TWOS     = 5;
   // transmit analog power-down codes
   localparam logic [2:0]   PDRX_TXA_OFF_A    = 3'h4;
   localparam logic [2:0]   PDRX_TXA_OFF_B    = 3'h2;
   localparam logic [2:0]   PDRX_TXA_OFF_AB   = 3'h7;
   // reset values
   localparam logic [7:0]   PDRX_RST_VAL      = 8'h00;
   // used-bit masks, other bits read zero
   localparam logic [7:0]   PDRX_MASK_PWR     = 8'hFE;
   localparam logic [7:0]   PDRX_MASK_CH_PD   = 8'hC0;
   localparam logic [7:0]   PDRX_MASK_REF     = 8'hF0;
   localparam logic [7:0]   PDRX_MASK_FMT     = 8'h20;
endpackage : pdrx_pkg

// File: rtl/pdrx_sample_fmt.sv
// module: per-channel receive sample formatter, straight binary or twos complement
`timescale 1ns/100ps
module pdrx_sample_fmt
   import pdrx_pkg::*;
#(
   parameter int W = PDRX_SAMPLE_W
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         twos_en,
   input  wire logic         hold,
   input  wire logic [W-1:0] sample_in,
   output      logic [W-1:0] sample_out
);
   typedef struct packed {
      logic [W-1:0] data;
   } pdrx_fmt_state_t;

   pdrx_fmt_state_t st_reg;
   pdrx_fmt_state_t st_next;

   // msb flip turns offset binary into twos complement; a powered-down path holds
   always_comb begin
      st_next = st_reg;
      if (!hold) begin
         st_next.data = twos_en ? {~sample_in[W-1], sample_in[W-2:0]}
                                : sample_in;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sample_out = st_reg.data;
endmodule : pdrx_sample_fmt

// File: rtl/pdrx_ctrl.sv
// module: power-down and receive format register bank with control outputs
//
// Summary of operation
// - tx analog field 100 kills output a, 010 output b, 111 both.
// - tx digital power-down resets low; transmit digital runs as configured.
// - tx digital power-down high gates the transmit digital clock.
// - while tx digital is gated, transmit outputs hold their last values.
// - rx digital power-down high powers down receive digital section.
// - unused digital blocks power down automatically without a write.
// - pll power-down high forces pll off and bypasses it.
// - pll disconnect high removes pll output from the clock path.
// - disconnected but powered pll keeps acquiring or holding lock.
// - channel bit 7 powers down its analog and digital; bandgap stays.
// - channel bit 6, reset low, disables that channel's input self-bias.
// - shared bit 7 powers down all receive bias incl. reference buffer.
// - shared bit 6 powers down internal converter reference circuits.
// - shared bit 5 powers down top and bottom differential references.
// - shared bit 4 powers down bandgap so external reference sets range.
// - samples are straight binary unless channel format bit 5 is set.
// - soft reset bit restores defaults, relocks pll, and self-clears.
// - no tx analog option powers down the converter bias current.
`timescale 1ns/100ps
module pdrx_ctrl
   import pdrx_pkg::*;
#(
   parameter int SW = PDRX_SAMPLE_W
) (
   input  wire logic                   ref_clk,
   input  wire logic                   arst_n,
   // register port
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [PDRX_ADDR_W-1:0] reg_addr,
   input  wire logic [PDRX_DATA_W-1:0] reg_wdata,
   output      logic [PDRX_DATA_W-1:0] reg_rdata,
   // usage hints from the mode logic
   input  wire logic                   tx_path_used,
   input  wire logic                   rx_a_used,
   input  wire logic                   rx_b_used,
   // receive samples in, formatted samples out
   input  wire logic [SW-1:0]          rx_a_sample,
   input  wire logic [SW-1:0]          rx_b_sample,
   output      logic [SW-1:0]          rx_a_data,
   output      logic [SW-1:0]          rx_b_data,
   // transmit side
   input  wire logic [SW-1:0]          tx_a_sample,
   input  wire logic [SW-1:0]          tx_b_sample,
   output      logic [SW-1:0]          tx_a_data,
   output      logic [SW-1:0]          tx_b_data,
   output      logic                   tx_dig_clk_en,
   output      logic                   tx_a_out_off,
   output      logic                   tx_b_out_off,
   output      logic                   tx_support_off,
   output      logic                   tx_bias_off,
   output      logic                   rx_dig_off,
   // clock multiplier
   output      logic                   pll_off,
   output      logic                   pll_bypass,
   output      logic                   pll_relock,
   // receive analog
   output      logic                   rx_a_analog_off,
   output      logic                   rx_b_analog_off,
   output      logic                   rx_a_selfbias_off,
   output      logic                   rx_b_selfbias_off,
   output      logic                   receive_bias_off,
   output      logic                   differential_reference_power_down,
   output      logic                   receive_reference_power_down,
   output      logic                   bandgap_off
);
   // every flop of the bank except the reset synchroniser and the two formatters lives in this one struct
   typedef struct packed {
      // register images
      logic [7:0]    pwr;
      logic [7:0]    rxa_pd;
      logic [7:0]    rxb_pd;
      logic [7:0]    rx_ref;
      logic [7:0]    rxa_fmt;
      logic [7:0]    rxb_fmt;
      // read data and the relock pulse
      logic [7:0]    rdata;
      logic          relock;
      // transmit side
      logic [SW-1:0] tx_a;
      logic [SW-1:0] tx_b;
      logic          tx_clk_en;
      logic          tx_a_off;
      logic          tx_b_off;
      logic          tx_sup_off;
      logic          tx_bias;
      // receive digital and clock multiplier
      logic          rx_off;
      logic          pll_pd;
      logic          pll_dis;
      // receive analog
      logic          a_ana;
      logic          b_ana;
      logic          a_bias;
      logic          b_bias;
      logic          bias_all;
      logic          rx_ref_pd;
      logic          diff_pd;
      logic          bg_pd;
   } pdrx_state_t;

   pdrx_state_t   st_reg;
   pdrx_state_t   st_next;
   logic [1:0]    rst_sync_reg;
   logic          rst_n;
   // receive channel 0 is a, channel 1 is b
   logic [1:0]    fmt_twos;
   logic [1:0]    fmt_hold;
   logic [SW-1:0] fmt_in  [2];
   logic [SW-1:0] fmt_out [2];

   // reset release through two flops so every flop leaves reset on one edge
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // used-bit mask per offset, shared by writes and reads
   // soft reset is write-only, so its offset keeps no bits and reads zero
   function automatic logic [7:0] reg_mask(input logic [5:0] a);
      logic [7:0] m;
      m = 8'h00;
      unique case (a)
         PDRX_OFS_PWR:     m = PDRX_MASK_PWR;
         PDRX_OFS_RXA_PD,
         PDRX_OFS_RXB_PD:  m = PDRX_MASK_CH_PD;
         PDRX_OFS_RX_REF:  m = PDRX_MASK_REF;
         PDRX_OFS_RXA_FMT,
         PDRX_OFS_RXB_FMT: m = PDRX_MASK_FMT;
         default:          m = 8'h00;
      endcase
      return m;
   endfunction : reg_mask

   // read mux, unused bits read zero
   function automatic logic [7:0] rd_mux(input pdrx_state_t s, input logic [5:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         PDRX_OFS_PWR:     v = s.pwr;
         PDRX_OFS_RXA_PD:  v = s.rxa_pd;
         PDRX_OFS_RXB_PD:  v = s.rxb_pd;
         PDRX_OFS_RX_REF:  v = s.rx_ref;
         PDRX_OFS_RXA_FMT: v = s.rxa_fmt;
         PDRX_OFS_RXB_FMT: v = s.rxb_fmt;
         default:          v = 8'h00;
      endcase
      return v & reg_mask(a);
   endfunction : rd_mux

   // tx analog code to {a off, b off, support off}; other codes turn nothing off
   function automatic logic [2:0] txa_decode(input logic [2:0] code);
      logic [2:0] o;
      o = 3'h0;
      unique case (code)
         PDRX_TXA_OFF_A:  o = 3'h4;
         PDRX_TXA_OFF_B:  o = 3'h2;
         PDRX_TXA_OFF_AB: o = 3'h7;
         default:         o = 3'h0;
      endcase
      return o;
   endfunction : txa_decode

   // register writes, soft reset, and decoded control outputs
   always_comb begin
      st_next        = st_reg;
      // relock is a one-cycle pulse, raised only by a soft reset write
      st_next.relock = 1'b0;
      // writes keep only the used bits, so unused bits read back zero
      if (reg_wr) begin
         unique case (reg_addr)
            PDRX_OFS_SOFT: begin
               // one-shot: nothing stored, so the bit reads back clear
               if (reg_wdata[PDRX_BIT_SOFT_RST]) begin
                  st_next.pwr     = PDRX_RST_VAL;
                  st_next.rxa_pd  = PDRX_RST_VAL;
                  st_next.rxb_pd  = PDRX_RST_VAL;
                  st_next.rx_ref  = PDRX_RST_VAL;
                  st_next.rxa_fmt = PDRX_RST_VAL;
                  st_next.rxb_fmt = PDRX_RST_VAL;
                  st_next.relock  = 1'b1;
               end
            end
            PDRX_OFS_PWR:     st_next.pwr     = reg_wdata & reg_mask(reg_addr);
            PDRX_OFS_RXA_PD:  st_next.rxa_pd  = reg_wdata & reg_mask(reg_addr);
            PDRX_OFS_RXB_PD:  st_next.rxb_pd  = reg_wdata & reg_mask(reg_addr);
            PDRX_OFS_RX_REF:  st_next.rx_ref  = reg_wdata & reg_mask(reg_addr);
            PDRX_OFS_RXA_FMT: st_next.rxa_fmt = reg_wdata & reg_mask(reg_addr);
            PDRX_OFS_RXB_FMT: st_next.rxb_fmt = reg_wdata & reg_mask(reg_addr);
            default: ;
         endcase
      end
      // a read in the same cycle as a write sees the old value
      st_next.rdata = reg_rd ? rd_mux(st_reg, reg_addr) : st_reg.rdata;

      // transmit analog decode; unlisted codes leave both outputs on
      {st_next.tx_a_off, st_next.tx_b_off, st_next.tx_sup_off} =
         txa_decode(st_reg.pwr[PDRX_TXA_MSB:PDRX_TXA_LSB]);
      // converter bias stays up in every code so tx recovery takes a few cycles
      st_next.tx_bias = 1'b0;

      // tx digital clock gate; an unused tx path is gated as well
      st_next.tx_clk_en = !st_reg.pwr[PDRX_BIT_TX_DIG] && tx_path_used;
      // outputs only follow the inputs while clocked, else hold last update
      if (st_reg.tx_clk_en) begin
         st_next.tx_a = tx_a_sample;
         st_next.tx_b = tx_b_sample;
      end

      // receive digital off by bit or when neither channel is in use
      st_next.rx_off = st_reg.pwr[PDRX_BIT_RX_DIG] || !(rx_a_used || rx_b_used);

      // pll: disconnect only reroutes, lock loop keeps running unless powered down
      st_next.pll_pd  = st_reg.pwr[PDRX_BIT_PLL_PD];
      st_next.pll_dis = st_reg.pwr[PDRX_BIT_PLL_DIS] || st_reg.pwr[PDRX_BIT_PLL_PD];

      // receive analog; bandgap is only touched by the shared vref bit
      // an unused channel powers down with no register write
      st_next.a_ana     = st_reg.rxa_pd[PDRX_BIT_CH_ANA] || !rx_a_used;
      st_next.b_ana     = st_reg.rxb_pd[PDRX_BIT_CH_ANA] || !rx_b_used;
      st_next.a_bias    = st_reg.rxa_pd[PDRX_BIT_CH_BIAS];
      st_next.b_bias    = st_reg.rxb_pd[PDRX_BIT_CH_BIAS];
      st_next.bias_all  = st_reg.rx_ref[PDRX_BIT_ANA_BIAS];
      st_next.rx_ref_pd = st_reg.rx_ref[PDRX_BIT_RX_REF];
      st_next.diff_pd   = st_reg.rx_ref[PDRX_BIT_DIFF_REF]
                       || st_reg.rx_ref[PDRX_BIT_ANA_BIAS];
      st_next.bg_pd     = st_reg.rx_ref[PDRX_BIT_VREF];
   end

   // one register stage for the whole bank, reset by the synchronised copy
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg           <= '0;
         // tx digital leaves reset clocked, as with its power-down bit low
         st_reg.tx_clk_en <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // a powered-down receive channel freezes its data
   assign fmt_hold[0] = st_reg.a_ana || st_reg.rx_off;
   assign fmt_hold[1] = st_reg.b_ana || st_reg.rx_off;
   assign fmt_twos[0] = st_reg.rxa_fmt[PDRX_BIT_TWOS];
   assign fmt_twos[1] = st_reg.rxb_fmt[PDRX_BIT_TWOS];
   assign fmt_in[0]   = rx_a_sample;
   assign fmt_in[1]   = rx_b_sample;

   // per-channel formatters, one per receive channel
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_fmt
         pdrx_sample_fmt #(.W(SW)) u_fmt (
            .ref_clk    (ref_clk),
            .rst_n      (rst_n),
            .twos_en    (fmt_twos[ch]),
            .hold       (fmt_hold[ch]),
            .sample_in  (fmt_in[ch]),
            .sample_out (fmt_out[ch])
         );
      end
   endgenerate

   // receive data comes from the formatter flops
   assign rx_a_data                         = fmt_out[0];
   assign rx_b_data                         = fmt_out[1];

   // read data and transmit side, straight from flops
   assign reg_rdata                         = st_reg.rdata;
   assign tx_a_data                         = st_reg.tx_a;
   assign tx_b_data                         = st_reg.tx_b;
   assign tx_dig_clk_en                     = st_reg.tx_clk_en;
   assign tx_a_out_off                      = st_reg.tx_a_off;
   assign tx_b_out_off                      = st_reg.tx_b_off;
   assign tx_support_off                    = st_reg.tx_sup_off;
   assign tx_bias_off                       = st_reg.tx_bias;
   assign rx_dig_off                        = st_reg.rx_off;

   // clock multiplier
   assign pll_off                           = st_reg.pll_pd;
   assign pll_bypass                        = st_reg.pll_dis;
   assign pll_relock                        = st_reg.relock;

   // receive analog
   assign rx_a_analog_off                   = st_reg.a_ana;
   assign rx_b_analog_off                   = st_reg.b_ana;
   assign rx_a_selfbias_off                 = st_reg.a_bias;
   assign rx_b_selfbias_off                 = st_reg.b_bias;
   assign receive_bias_off                  = st_reg.bias_all;
   assign differential_reference_power_down = st_reg.diff_pd;
   assign receive_reference_power_down      = st_reg.rx_ref_pd;
   assign bandgap_off                       = st_reg.bg_pd;
endmodule : pdrx_ctrl

// File: sim/pdrx_ctrl_assertions.sv
// checker: port-level properties of the power-down and format bank
`timescale 1ns/100ps
module pdrx_ctrl_assertions
   import pdrx_pkg::*;
#(
   parameter int SW = PDRX_SAMPLE_W
) (
   input wire logic                   ref_clk,
   input wire logic                   arst_n,
   input wire logic                   reg_wr,
   input wire logic [PDRX_ADDR_W-1:0] reg_addr,
   input wire logic [PDRX_DATA_W-1:0] reg_wdata,
   input wire logic                   rx_a_used,
   input wire logic                   rx_b_used,
   input wire logic [SW-1:0]          tx_a_data,
   input wire logic [SW-1:0]          tx_b_data,
   input wire logic                   tx_dig_clk_en,
   input wire logic                   tx_a_out_off,
   input wire logic                   tx_b_out_off,
   input wire logic                   tx_bias_off,
   input wire logic                   rx_dig_off,
   input wire logic                   pll_off,
   input wire logic                   pll_bypass,
   input wire logic                   pll_relock,
   input wire logic                   rx_a_analog_off
);
   logic [2:0] up_cnt_reg;
   // outputs sit at reset values while the internal reset copy drains
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) up_cnt_reg <= 3'h0;
      else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_bias_stays_on: assert property (tx_bias_off == 1'b0)
      else $error("tx bias switched off");
   a_tx_a_code: assert property (reg_wr && reg_addr == PDRX_OFS_PWR
      && reg_wdata[7:5] inside {3'h4, 3'h7} |-> ##2 tx_a_out_off) else $error("tx a not off");
   a_tx_b_code: assert property (reg_wr && reg_addr == PDRX_OFS_PWR
      && reg_wdata[7:5] inside {3'h2, 3'h7} |-> ##2 tx_b_out_off) else $error("tx b not off");
   a_pll_off_bypass: assert property (pll_off |-> pll_bypass)
      else $error("pll off without bypass");
   a_tx_hold_data: assert property (!tx_dig_clk_en && !$past(tx_dig_clk_en)
      |-> $stable(tx_a_data) && $stable(tx_b_data)) else $error("tx data moved while gated");
   a_relock_one_cycle: assert property (pll_relock |=> !pll_relock)
      else $error("relock pulse too long");
   a_soft_relock: assert property (reg_wr && reg_addr == PDRX_OFS_SOFT
      && reg_wdata[5] |=> pll_relock) else $error("no relock after soft reset");
   a_rx_dig_auto: assert property ((up_cnt_reg == 3'h7 && !rx_a_used && !rx_b_used) [*3]
      |-> rx_dig_off) else $error("unused rx digital still on");
   a_rx_a_auto: assert property ((up_cnt_reg == 3'h7 && !rx_a_used) [*3]
      |-> rx_a_analog_off) else $error("unused rx a still on");
endmodule : pdrx_ctrl_assertions

bind pdrx_ctrl pdrx_ctrl_assertions #(.SW(SW)) u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rx_a_used(rx_a_used),
   .rx_b_used(rx_b_used), .tx_a_data(tx_a_data), .tx_b_data(tx_b_data),
   .tx_dig_clk_en(tx_dig_clk_en), .tx_a_out_off(tx_a_out_off), .tx_b_out_off(tx_b_out_off),
   .tx_bias_off(tx_bias_off), .rx_dig_off(rx_dig_off), .pll_off(pll_off),
   .pll_bypass(pll_bypass), .pll_relock(pll_relock), .rx_a_analog_off(rx_a_analog_off));

// File: sim/pdrx_ctrl_test.sv
// testbench: register bank, power-down controls and sample formatting
`timescale 1ns/100ps
module pdrx_ctrl_test;
   import pdrx_pkg::*;
   logic        ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_taken = 1'b0;
   logic        tx_path_used = 1'b1, rx_a_used = 1'b1, rx_b_used = 1'b1;
   logic [5:0]  reg_addr = 6'h00;
   logic [7:0]  reg_wdata = 8'h00, d;
   logic [11:0] rx_a_sample = 12'h000, rx_b_sample = 12'h000, ta, ra;
   logic [11:0] tx_a_sample = 12'h000, tx_b_sample = 12'h000;
   logic [7:0]  reg_rdata, rd_q[$];
   logic [11:0] rx_a_data, rx_b_data, tx_a_data, tx_b_data;
   logic        tx_dig_clk_en, tx_a_out_off, tx_b_out_off, tx_support_off, tx_bias_off;
   logic        rx_dig_off, pll_off, pll_bypass, pll_relock, rx_a_analog_off, rx_b_analog_off;
   logic        rx_a_selfbias_off, rx_b_selfbias_off, receive_bias_off, bandgap_off;
   logic        differential_reference_power_down, receive_reference_power_down;
   logic [7:0]  msk [2:7] = '{PDRX_MASK_PWR, PDRX_MASK_CH_PD, PDRX_MASK_CH_PD, PDRX_MASK_REF,
                             PDRX_MASK_FMT, PDRX_MASK_FMT};
   logic [31:0] seed = 32'd15995;
   int          mismatches = 0, checks_done = 0, cyc = 0;

   pdrx_ctrl uut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .tx_path_used(tx_path_used), .rx_a_used(rx_a_used), .rx_b_used(rx_b_used),
      .rx_a_sample(rx_a_sample), .rx_b_sample(rx_b_sample), .rx_a_data(rx_a_data),
      .rx_b_data(rx_b_data), .tx_a_sample(tx_a_sample), .tx_b_sample(tx_b_sample),
      .tx_a_data(tx_a_data), .tx_b_data(tx_b_data), .tx_dig_clk_en(tx_dig_clk_en),
      .tx_a_out_off(tx_a_out_off), .tx_b_out_off(tx_b_out_off), .tx_support_off(tx_support_off),
      .tx_bias_off(tx_bias_off), .rx_dig_off(rx_dig_off), .pll_off(pll_off),
      .pll_bypass(pll_bypass), .pll_relock(pll_relock), .rx_a_analog_off(rx_a_analog_off),
      .rx_b_analog_off(rx_b_analog_off), .rx_a_selfbias_off(rx_a_selfbias_off),
      .rx_b_selfbias_off(rx_b_selfbias_off), .receive_bias_off(receive_bias_off),
      .differential_reference_power_down(differential_reference_power_down),
      .receive_reference_power_down(receive_reference_power_down), .bandgap_off(bandgap_off));

   // one clock feeds every path, so a bypassed pll still sees the tx rate
   always #50 ref_clk = ~ref_clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task automatic chk(string n, logic [11:0] e, logic [11:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // inputs move 10 ns after the edge so the design never sees a race
   task automatic step(int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask : step

   // strobe dropped then three idle edges, so back-to-back calls never re-raise it in one step
   task automatic wr(logic [5:0] a, logic [7:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      step(1);
      reg_wr = 1'b0;
      step(3);
   endtask : wr

   task automatic rd(logic [5:0] a, logic [7:0] e);
      rd_q.push_back(e);
      reg_rd = 1'b1;
      reg_addr = a;
      step(1);
      reg_rd = 1'b0;
      step(1);
   endtask : rd

   // read data lands on the taking edge; compared half a cycle later
   always @(posedge ref_clk) rd_taken <= reg_rd;
   always @(negedge ref_clk) if (rd_taken) chk("reg_rdata", 12'(rd_q.pop_front()), 12'(reg_rdata));

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         close_out();
      end
   end

   initial begin
      step(10);
      arst_n = 1'b1;
      step(5);
      chk("tx_dig_clk_en", 12'h001, 12'(tx_dig_clk_en));
      for (int a = 0; a < 8; a++) rd(6'(a), 8'h00);
      for (int a = 2; a < 8; a++) begin
         d = 8'(xs());
         wr(6'(a), d);
         rd(6'(a), d & msk[a]);
      end
      wr(6'h3F, 8'hFF);
      rd(6'h3F, 8'h00);
      // soft reset: relock pulse then every register back to zero
      reg_wr = 1'b1;
      reg_addr = PDRX_OFS_SOFT;
      reg_wdata = 8'h20;
      step(1);
      reg_wr = 1'b0;
      chk("pll_relock", 12'h001, 12'(pll_relock));
      step(1);
      chk("pll_relock", 12'h000, 12'(pll_relock));
      step(2);
      for (int a = 0; a < 8; a++) rd(6'(a), 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(PDRX_OFS_PWR, 8'(c << 5));
         chk("tx_a_out_off", 12'(c == 4 || c == 7), 12'(tx_a_out_off));
         chk("tx_b_out_off", 12'(c == 2 || c == 7), 12'(tx_b_out_off));
         chk("tx_support_off", 12'(c == 7), 12'(tx_support_off));
         chk("tx_bias_off", 12'h000, 12'(tx_bias_off));
      end
      wr(PDRX_OFS_PWR, 8'h04);
      chk("pll_off", 12'h001, 12'(pll_off));
      chk("pll_bypass", 12'h001, 12'(pll_bypass));
      wr(PDRX_OFS_PWR, 8'h02);
      chk("pll_off", 12'h000, 12'(pll_off));
      chk("pll_bypass", 12'h001, 12'(pll_bypass));
      wr(PDRX_OFS_PWR, 8'h08);
      chk("rx_dig_off", 12'h001, 12'(rx_dig_off));
      ta = 12'(xs());
      tx_a_sample = ta;
      tx_b_sample = ~ta;
      wr(PDRX_OFS_PWR, 8'h10);
      chk("tx_dig_clk_en", 12'h000, 12'(tx_dig_clk_en));
      tx_a_sample = ~ta;
      tx_b_sample = ta;
      step(3);
      chk("tx_a_data", ta, tx_a_data);
      chk("tx_b_data", ~ta, tx_b_data);
      wr(PDRX_OFS_PWR, 8'h00);
      chk("tx_a_data", ~ta, tx_a_data);
      chk("tx_b_data", ta, tx_b_data);
      wr(PDRX_OFS_RXA_FMT, 8'h20);
      ra = 12'(xs());
      rx_a_sample = ra;
      rx_b_sample = ~ra;
      step(2);
      chk("rx_a_data", ra ^ 12'h800, rx_a_data);
      chk("rx_b_data", ~ra, rx_b_data);
      wr(PDRX_OFS_RXA_PD, 8'hC0);
      chk("rx_a_selfbias_off", 12'h001, 12'(rx_a_selfbias_off));
      chk("rx_a_analog_off", 12'h001, 12'(rx_a_analog_off));
      rx_a_sample = ~ra;
      step(2);
      chk("rx_a_data", ra ^ 12'h800, rx_a_data);
      wr(PDRX_OFS_RXB_PD, 8'h40);
      chk("rx_b_analog_off", 12'h000, 12'(rx_b_analog_off));
      chk("rx_b_selfbias_off", 12'h001, 12'(rx_b_selfbias_off));
      for (int i = 4; i < 8; i++) begin
         wr(PDRX_OFS_RX_REF, 8'(1 << i));
         chk("bandgap_off", 12'(i == 4), 12'(bandgap_off));
         chk("diff_ref_off", 12'(i == 5 || i == 7), 12'(differential_reference_power_down));
         chk("rx_ref_off", 12'(i == 6), 12'(receive_reference_power_down));
         chk("rx_bias_off", 12'(i == 7), 12'(receive_bias_off));
      end
      rx_b_used = 1'b0;
      step(4);
      chk("rx_b_analog_off", 12'h001, 12'(rx_b_analog_off));
      chk("rx_dig_off", 12'h000, 12'(rx_dig_off));
      rx_a_used = 1'b0;
      step(4);
      chk("rx_dig_off", 12'h001, 12'(rx_dig_off));
      close_out();
   end
endmodule : pdrx_ctrl_test
